// ===== design/ssa_pkg.sv
// Purpose: constants and types of the serial SAR converter interface
// Assumes: system clock 25 MHz, link clock supplied by the host
package ssa_pkg;

    localparam int CMD_BITS = 4;
    localparam int RES_BITS = 10;
    localparam int CNT_BITS = 4;
    localparam int CONV_CNT_BITS = 10;

    localparam logic [CNT_BITS-1:0] EDGE_SAMPLE = 4'h4;
    localparam logic [CNT_BITS-1:0] EDGE_HOLD = 4'hA;

    localparam logic [CMD_BITS-1:0] CMD_CH_LAST = 4'h7;
    localparam logic [CMD_BITS-1:0] CMD_PDOWN = 4'h8;
    localparam logic [CMD_BITS-1:0] CMD_FAST = 4'h9;
    localparam logic [CMD_BITS-1:0] CMD_SLOW = 4'hA;
    localparam logic [CMD_BITS-1:0] CMD_ST_MID = 4'hB;
    localparam logic [CMD_BITS-1:0] CMD_ST_LO = 4'hC;
    localparam logic [CMD_BITS-1:0] CMD_ST_HI = 4'hD;

    localparam logic [RES_BITS-1:0] RES_MID = 10'h200;
    localparam logic [RES_BITS-1:0] RES_LO = 10'h000;
    localparam logic [RES_BITS-1:0] RES_HI = 10'h3FF;
    localparam logic [RES_BITS-1:0] RES_RESET = 10'h000;

    localparam int CLK_PERIOD_NS = 40;
    localparam int FAST_CONV_NS = 10000;
    localparam int SLOW_CONV_NS = 40000;
    localparam logic [CONV_CNT_BITS-1:0] FAST_CONV_CYC =
        CONV_CNT_BITS'((FAST_CONV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CONV_CNT_BITS-1:0] SLOW_CONV_CYC =
        CONV_CNT_BITS'((SLOW_CONV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    typedef enum logic [2:0] {
        SSA_IDLE = 3'b001,
        SSA_CONV = 3'b010,
        SSA_EXT = 3'b100
    } ssa_state_t;

    // command handed from the link side to the system side
    typedef struct packed {
        logic [CMD_BITS-1:0] code;
    } ssa_cmd_t;

endpackage : ssa_pkg

// ===== design/ssa_sync.sv
// Purpose: two-flop level synchroniser
// Assumes: source is quasi-static relative to clk_i
// Notes: first stage read only by the second
`timescale 1ns/1ps
`default_nettype none
module ssa_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clk_i) begin
        meta_q <= d_i;
        q_o <= meta_q;
    end
endmodule : ssa_sync
`default_nettype wire

// ===== design/ssa_link.sv
// Purpose: frame engine on the host bit clock
// Assumes: select high acts as asynchronous idle for frame state
// Notes: commands sampled on falling edges, result driven on rising
`timescale 1ns/1ps
`default_nettype none
module ssa_link (
    input wire logic lclk_i,
    input wire logic arst_i,
    input wire logic cs_n_i,
    input wire logic fs_i,
    input wire logic din_i,
    input wire logic [ssa_pkg::RES_BITS-1:0] result_i,
    output logic dout_o,
    output logic dout_oe_n_o,
    output logic track_o,
    output logic [2:0] chan_o,
    output ssa_pkg::ssa_cmd_t cmd_o,
    output logic start_tgl_o
);
    logic armed_q;
    logic [ssa_pkg::CNT_BITS-1:0] cnt_q;
    logic [ssa_pkg::CMD_BITS-1:0] cmd_sh_q;
    logic go_q;
    logic [ssa_pkg::RES_BITS-1:0] sh_q;

    wire [ssa_pkg::CNT_BITS-1:0] cnt_inc = cnt_q + 4'h1;
    wire [ssa_pkg::CMD_BITS-1:0] cmd_next = {cmd_sh_q[ssa_pkg::CMD_BITS-2:0], din_i};
    wire at_sample = armed_q && (cnt_inc == ssa_pkg::EDGE_SAMPLE);
    wire at_hold = armed_q && (cnt_inc == ssa_pkg::EDGE_HOLD);

    // ************************************************
    // falling-edge side: command, sample, hold
    // ************************************************
    always_ff @(negedge lclk_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            armed_q <= 1'b0;
            cnt_q <= '0;
            cmd_sh_q <= '0;
            track_o <= 1'b0;
        end else if (fs_i) begin
            armed_q <= 1'b1;
            cnt_q <= '0;
        end else if (armed_q) begin
            cnt_q <= cnt_inc;
            if (cnt_inc <= ssa_pkg::EDGE_SAMPLE) begin
                cmd_sh_q <= cmd_next;
            end
            if (at_sample) begin
                track_o <= (cmd_next <= ssa_pkg::CMD_CH_LAST);
            end
            if (at_hold) begin
                track_o <= 1'b0;
                armed_q <= 1'b0;
            end
        end
    end

    // survives select so the system side sees a stable word
    always_ff @(negedge lclk_i or posedge arst_i) begin
        if (arst_i) begin
            cmd_o <= '0;
            chan_o <= '0;
            start_tgl_o <= 1'b0;
        end else if (!cs_n_i) begin
            if (at_sample) begin
                cmd_o.code <= cmd_next;
                chan_o <= cmd_next[2:0];
            end
            if (at_hold) begin
                start_tgl_o <= ~start_tgl_o;
            end
        end
    end

    // ************************************************
    // rising-edge side: result shifter
    // ************************************************
    always_ff @(posedge lclk_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            dout_oe_n_o <= 1'b1;
            dout_o <= 1'b0;
            go_q <= 1'b0;
            sh_q <= '0;
        end else begin
            dout_oe_n_o <= 1'b0;
            if (fs_i) begin
                // msb leaves together with the first command bit
                sh_q <= {result_i[ssa_pkg::RES_BITS-2:0], 1'b0};
                go_q <= 1'b1;
                dout_o <= result_i[ssa_pkg::RES_BITS-1];
            end else if (go_q) begin
                dout_o <= sh_q[ssa_pkg::RES_BITS-1];
                sh_q <= {sh_q[ssa_pkg::RES_BITS-2:0], 1'b0};
            end
        end
    end
endmodule : ssa_link
`default_nettype wire

// ===== design/ssa_top.sv
// Purpose: serial SAR converter interface, device side
// Assumes: sys clock 25 MHz; analog code presented on adc_code_i
// Notes: link logic runs on the host bit clock
`timescale 1ns/1ps
`default_nettype none
module ssa_top #(
    parameter bit EIGHT_INPUT = 1'b1
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic io_clk_i,
    input wire logic cs_n_i,
    input wire logic frame_start_pulse_i,
    input wire logic din_i,
    input wire logic clock_phase_invert_n_i,
    input wire logic conversion_start_n_i,
    input wire logic [ssa_pkg::RES_BITS-1:0] adc_code_i,
    output logic dout_o,
    output logic dout_oe_n_o,
    output logic eoc_o,
    output logic track_o,
    output logic [2:0] chan_o,
    output logic ext_track_o,
    output logic convert_o,
    output logic power_down_o,
    output logic fast_rate_o
);
    // ************************************************
    // link clock and frame engine
    // ************************************************
    wire lclk = io_clk_i ^ clock_phase_invert_n_i;
    ssa_pkg::ssa_cmd_t link_cmd;
    logic link_tgl;
    logic [2:0] link_chan;
    logic [ssa_pkg::RES_BITS-1:0] result_q;

    ssa_link u_link (
        .lclk_i(lclk),
        .arst_i(sys_rst_i),
        .cs_n_i(cs_n_i),
        .fs_i(frame_start_pulse_i),
        .din_i(din_i),
        .result_i(result_q),
        .dout_o(dout_o),
        .dout_oe_n_o(dout_oe_n_o),
        .track_o(track_o),
        .chan_o(link_chan),
        .cmd_o(link_cmd),
        .start_tgl_o(link_tgl)
    );

    // four-input parts map even codes onto inputs 0..3
    assign chan_o = EIGHT_INPUT ? link_chan : {1'b0, link_chan[2:1]};

    // ************************************************
    // crossings into the system clock
    // ************************************************
    logic tgl_s;
    logic conversion_start_n_n_s;
    logic [ssa_pkg::RES_BITS-1:0] code_s;

    ssa_sync #(.WIDTH(1)) u_sync_tgl (
        .clk_i(clk_i),
        .d_i(link_tgl),
        .q_o(tgl_s)
    );
    ssa_sync #(.WIDTH(1)) u_sync_cst (
        .clk_i(clk_i),
        .d_i(conversion_start_n_i),
        .q_o(conversion_start_n_n_s)
    );
    ssa_sync #(.WIDTH(ssa_pkg::RES_BITS)) u_sync_code (
        .clk_i(clk_i),
        .d_i(adc_code_i),
        .q_o(code_s)
    );

    // ************************************************
    // command decode
    // ************************************************
    logic tgl_last_q;
    logic cst_last_q;
    ssa_pkg::ssa_state_t state_q;
    ssa_pkg::ssa_state_t state_d;
    logic [ssa_pkg::CONV_CNT_BITS-1:0] conv_cnt_q;
    logic [ssa_pkg::CMD_BITS-1:0] conv_cmd_q;
    logic pd_q;
    logic fast_q;

    wire start_evt = tgl_s ^ tgl_last_q;
    wire [ssa_pkg::CMD_BITS-1:0] code = link_cmd.code; // stable since fourth edge
    wire is_chan = code <= ssa_pkg::CMD_CH_LAST;
    wire is_test = (code >= ssa_pkg::CMD_ST_MID) && (code <= ssa_pkg::CMD_ST_HI);
    wire does_conv = is_chan || is_test;
    wire ext_fall = cst_last_q && !conversion_start_n_n_s;
    wire ext_rise = !cst_last_q && conversion_start_n_n_s;
    wire [ssa_pkg::CONV_CNT_BITS-1:0] conv_len =
        fast_q ? ssa_pkg::FAST_CONV_CYC : ssa_pkg::SLOW_CONV_CYC;
    wire conv_end = (state_q == ssa_pkg::SSA_CONV) && (conv_cnt_q == '0);

    logic [ssa_pkg::RES_BITS-1:0] conv_value;
    always_comb begin
        case (conv_cmd_q)
            ssa_pkg::CMD_ST_MID: conv_value = ssa_pkg::RES_MID;
            ssa_pkg::CMD_ST_LO: conv_value = ssa_pkg::RES_LO;
            ssa_pkg::CMD_ST_HI: conv_value = ssa_pkg::RES_HI;
            default: conv_value = code_s;
        endcase
    end

    // ************************************************
    // conversion state machine
    // ************************************************
    always_comb begin
        state_d = state_q;
        case (state_q)
            ssa_pkg::SSA_IDLE: begin
                if (start_evt && does_conv && !pd_q) begin
                    state_d = ssa_pkg::SSA_CONV;
                end else if (ext_fall) begin
                    state_d = ssa_pkg::SSA_EXT;
                end
            end
            ssa_pkg::SSA_EXT: begin
                if (ext_rise) begin
                    state_d = ssa_pkg::SSA_CONV;
                end
            end
            ssa_pkg::SSA_CONV: begin
                if (conv_end) begin
                    state_d = ssa_pkg::SSA_IDLE;
                end
            end
            default: state_d = ssa_pkg::SSA_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state_q <= ssa_pkg::SSA_IDLE;
            tgl_last_q <= tgl_s;
            cst_last_q <= 1'b1;
            conv_cnt_q <= '0;
            conv_cmd_q <= '0;
            result_q <= ssa_pkg::RES_RESET;
            pd_q <= 1'b0;
            fast_q <= 1'b1;
        end else begin
            state_q <= state_d;
            tgl_last_q <= tgl_s;
            cst_last_q <= conversion_start_n_n_s;
            if (start_evt) begin
                pd_q <= (code == ssa_pkg::CMD_PDOWN);
                if (code == ssa_pkg::CMD_FAST) begin
                    fast_q <= 1'b1;
                end
                if (code == ssa_pkg::CMD_SLOW) begin
                    fast_q <= 1'b0;
                end
                if (does_conv) begin
                    conv_cmd_q <= code;
                end
            end
            if (state_d == ssa_pkg::SSA_CONV && state_q != ssa_pkg::SSA_CONV) begin
                conv_cnt_q <= conv_len - 10'h001;
            end else if (state_q == ssa_pkg::SSA_CONV && conv_cnt_q != '0) begin
                conv_cnt_q <= conv_cnt_q - 10'h001;
            end
            if (conv_end) begin
                result_q <= conv_value;
            end
        end
    end

    // ************************************************
    // registered outputs
    // ************************************************
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            eoc_o <= 1'b1;
            ext_track_o <= 1'b0;
            convert_o <= 1'b0;
            power_down_o <= 1'b0;
            fast_rate_o <= 1'b1;
        end else begin
            eoc_o <= (state_d != ssa_pkg::SSA_CONV);
            ext_track_o <= (state_d == ssa_pkg::SSA_EXT);
            convert_o <= (state_d == ssa_pkg::SSA_CONV);
            power_down_o <= pd_q;
            fast_rate_o <= fast_q;
        end
    end
endmodule : ssa_top
`default_nettype wire

// ===== tb/ssa_monitor.sv
// Purpose: port checker of the serial converter interface
// Assumes: bound to ssa_top, link clock stops outside frames
// Notes: link checks sampled on falling link edges
`timescale 1ns/1ps
`default_nettype none
module ssa_monitor (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic io_clk_i,
    input wire logic cs_n_i,
    input wire logic frame_start_pulse_i,
    input wire logic din_i,
    input wire logic dout_o,
    input wire logic dout_oe_n_o,
    input wire logic eoc_o,
    input wire logic track_o,
    input wire logic convert_o,
    input wire logic power_down_o,
    input wire logic fast_rate_o
);
    // ****************************************
    // helpers and assertions
    // ****************************************
    logic [10:0] low_cnt_q;
    logic [10:0] conv_len;
    assign conv_len = fast_rate_o ? 11'(ssa_pkg::FAST_CONV_CYC) : 11'(ssa_pkg::SLOW_CONV_CYC);
    always_ff @(posedge clk_i) begin
        low_cnt_q <= (sys_rst_i || eoc_o) ? 11'h000 : low_cnt_q + 11'h001;
    end
    sequence s_armed;
        !cs_n_i && frame_start_pulse_i;
    endsequence
    a_idle_float: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        cs_n_i ##1 cs_n_i |-> dout_oe_n_o) else $error("output driven while idle");
    a_drive_low: assert property (@(negedge io_clk_i) disable iff (sys_rst_i)
        s_armed |-> !dout_oe_n_o && !dout_o) else $error("output not driven low");
    a_pad_zero: assert property (@(negedge io_clk_i) disable iff (sys_rst_i)
        s_armed ##11 !cs_n_i |-> !dout_o) else $error("padding bit not zero");
    a_track_early: assert property (@(negedge io_clk_i) disable iff (sys_rst_i)
        s_armed ##4 1'b1 |-> !track_o) else $error("sampling before fourth edge");
    a_track_start: assert property (@(negedge io_clk_i) disable iff (sys_rst_i)
        s_armed ##0 !power_down_o ##1 !din_i ##4 !cs_n_i |-> track_o)
        else $error("channel not sampled");
    a_hold_ten: assert property (@(negedge io_clk_i) disable iff (sys_rst_i)
        s_armed ##11 !cs_n_i |-> !track_o) else $error("sample not held at tenth edge");
    a_done_conv: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        $fell(eoc_o) |-> convert_o) else $error("done fell without conversion");
    a_conv_time: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        $rose(eoc_o) |-> low_cnt_q + 11'h004 >= conv_len && low_cnt_q <= conv_len + 11'h004)
        else $error("conversion length wrong");
    a_pd_idle: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        power_down_o |-> eoc_o) else $error("conversion in power-down");
endmodule : ssa_monitor
`default_nettype wire

// ===== tb/ssa_host.sv
// Purpose: host serial port model, master of the link
// Assumes: 48 ns bit clock, stopped between frames
// Notes: changes signals after rising edges, samples on falling
`timescale 1ns/1ps
`default_nettype none
module ssa_host (
    output var logic io_clk_o,
    output var logic cs_n_o,
    output var logic fs_o,
    output var logic din_o,
    input wire logic dout_i,
    input wire logic eoc_i
);
    // ****************************************
    // frame task
    // ****************************************
    // non-blocking so the select edge reaches waiting link flops
    initial begin
        io_clk_o <= 1'b0;
        cs_n_o <= 1'b1;
        fs_o <= 1'b0;
        din_o <= 1'b0;
    end
    task automatic frame(input logic [3:0] cmd, input int n, output logic [15:0] rx);
        rx = 16'h0000;
        wait (eoc_i === 1'b1);
        #100;
        cs_n_o = 1'b0;
        for (int i = 0; i <= n; i++) begin
            #24 io_clk_o = 1'b1;
            #2;
            fs_o = (i == 0);
            din_o = (i >= 1 && i <= 4) ? cmd[4 - i] : ~din_o;
            #22 io_clk_o = 1'b0;
            if (i > 0) rx = {rx[14:0], dout_i};
        end
        #10 cs_n_o = 1'b1;
        din_o = ~din_o;
    endtask : frame
endmodule : ssa_host
`default_nettype wire

// ===== tb/testbench.sv
// Purpose: self-checking bench of the serial converter interface
// Assumes: eight-input variant, phase invert off
// Notes: codes 0..F in order, then random codes and codes
`timescale 1ns/1ps
`default_nettype none
module testbench;
    // ****************************************
    // bench
    // ****************************************
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b0;
    logic conversion_start_n_n = 1'b1;
    logic io_clk_i, cs_n_i, frame_start_pulse_i, din_i;
    logic [9:0] adc_code_i;
    logic dout_o, dout_oe_n_o, eoc_o, track_o, ext_track_o, convert_o, power_down_o, fast_rate_o;
    logic [2:0] chan_o;
    logic [3:0] c;
    logic [15:0] rx;
    logic [15:0] seed = 16'h0041;
    logic [9:0] prev = 10'h000;
    logic pd = 1'b0;
    logic fast = 1'b1;
    logic conv;
    int n, cnt, len, fails, num_checks;
    always #20 clk_i = ~clk_i;
    ssa_top i_dut (.clk_i, .sys_rst_i, .io_clk_i, .cs_n_i, .frame_start_pulse_i, .din_i,
        .clock_phase_invert_n_i(1'b0), .conversion_start_n_i(conversion_start_n_n), .adc_code_i, .dout_o,
        .dout_oe_n_o, .eoc_o, .track_o, .chan_o, .ext_track_o, .convert_o, .power_down_o,
        .fast_rate_o);
    ssa_host i_host (.io_clk_o(io_clk_i), .cs_n_o(cs_n_i), .fs_o(frame_start_pulse_i),
        .din_o(din_i), .dout_i(dout_oe_n_o ? ~dout_o : dout_o), .eoc_i(eoc_o));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : report_and_stop
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    function automatic logic [9:0] result_of(input logic [3:0] k, input logic [9:0] a);
        case (k)
            4'hB: return 10'h200;
            4'hC: return 10'h000;
            4'hD: return 10'h3FF;
            default: return a;
        endcase
    endfunction : result_of
    initial begin
        #3_000_000;
        fails++;
        report_and_stop();
    end
    initial begin
        sys_rst_i <= 1'b1;
        adc_code_i = 10'h000;
        repeat (16) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        check(16'(eoc_o), 16'h0001);
        for (int k = 0; k < 40; k++) begin
            c = (k < 16) ? 4'(k) : seed[3:0];
            n = (k % 3 == 0) ? 10 : 16;
            @(posedge clk_i);
            adc_code_i <= seed[15:6];
            seed = lfsr(seed);
            i_host.frame(c, n, rx);
            #1;
            check(rx, (n == 16) ? {prev, 6'h00} : {6'h00, prev});
            check(16'(dout_oe_n_o), 16'h0001);
            conv = !pd && (c <= 4'h7 || (c >= 4'hB && c <= 4'hD));
            repeat (8) @(posedge clk_i);
            check(16'(eoc_o), 16'(!conv));
            len = fast ? 250 : 1000;
            cnt = 8;
            while (conv && eoc_o !== 1'b1 && cnt < 1100) begin
                @(posedge clk_i);
                cnt++;
            end
            if (conv) begin
                check(16'(cnt > len - 8 && cnt < len + 6), 16'h0001);
                if (c <= 4'h7) check(16'(chan_o), 16'(c[2:0]));
                prev = result_of(c, adc_code_i);
            end
            pd = (c == 4'h8);
            fast = (c == 4'h9) ? 1'b1 : ((c == 4'hA) ? 1'b0 : fast);
            check(16'({power_down_o, fast_rate_o}), 16'({pd, fast}));
        end
        // extended sampling: start input opens sampling, release converts
        conversion_start_n_n <= 1'b0;
        repeat (6) @(posedge clk_i);
        check(16'({ext_track_o, eoc_o}), 16'h0003);
        conversion_start_n_n <= 1'b1;
        repeat (8) @(posedge clk_i);
        check(16'({ext_track_o, eoc_o}), 16'h0000);
        len = fast ? 250 : 1000;
        cnt = 0;
        while (eoc_o !== 1'b1 && cnt < 1100) begin
            @(posedge clk_i);
            cnt++;
        end
        check(16'(cnt > len - 8 && cnt < len + 6), 16'h0001);
        report_and_stop();
    end
endmodule : testbench
bind ssa_top ssa_monitor i_mon (.clk_i, .sys_rst_i, .io_clk_i, .cs_n_i, .frame_start_pulse_i,
    .din_i, .dout_o, .dout_oe_n_o, .eoc_o, .track_o, .convert_o, .power_down_o, .fast_rate_o);
`default_nettype wire
